// >>> arxop_core.sv
// accumulator rotate, exchange, bank select and timer start/stop unit
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module arxop_core import arxop_pkg::*; #(
  parameter int DMEM_ADDR_W = 6
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // instruction issue
  input wire logic instr_valid,
  input wire logic [7:0] instr_opcode,
  output logic instr_ready,
  // event counter pin
  input wire logic event_count_input,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);

  function automatic logic [7:0] wreg_addr(input logic bank,
                                           input logic [2:0] slot);
    wreg_addr = (bank ? BANK1_BASE : BANK0_BASE) + {5'h00, slot};
  endfunction

  logic rst_meta_n;
  logic rst_n;
  logic [7:0] acc;
  logic [7:0] program_status_word;
  logic [7:0] counter;
  logic [PRESC_W-1:0] prescaler;
  arxop_tmode_e tmode;
  arxop_state_e state;
  logic [DMEM_ADDR_W-1:0] eng_addr;
  logic event_prev;
  logic rd_mem_q;
  logic [7:0] rd_q;
  logic [7:0] mem_a_q;
  logic [7:0] mem_b_q;
  logic bank_select_flag;
  logic carry_flag;
  logic fire;
  logic is_trade_reg;
  logic is_trade_ind;
  logic tc_cmd;
  logic ev_fall;
  logic tick;
  logic wr_acc;
  logic wr_stat;
  logic wr_cnt;
  logic bus_mem_wr;
  logic bus_mem_rd;
  logic eng_wr;
  logic b_re;
  logic [DMEM_ADDR_W-1:0] b_addr;
  logic [2:0] slot_idx;
  logic [7:0] reg_slot;
  logic mem_wr_en;
  logic [DMEM_ADDR_W-1:0] mem_wr_addr;
  logic [7:0] mem_wr_data;

  // reset released through two flops
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  assign bank_select_flag = program_status_word[STAT_BANK_BIT];
  assign carry_flag = program_status_word[STAT_CARRY_BIT];
  assign instr_ready = (state == ST_IDLE);
  assign fire = instr_valid & instr_ready & clk_en;
  assign is_trade_reg = (instr_opcode[7:3] == OP_TRADE_REG);
  assign is_trade_ind = (instr_opcode[7:1] == OP_TRADE_IND);
  assign tc_cmd = fire & ((instr_opcode == OP_HALT_TC) |
                          (instr_opcode == OP_BEGIN_EVT) |
                          (instr_opcode == OP_BEGIN_TMR));
  assign wr_acc = clk_en & reg_wr & (reg_addr == REG_ACC);
  assign wr_stat = clk_en & reg_wr & (reg_addr == REG_STATUS_WORD);
  assign wr_cnt = clk_en & reg_wr & (reg_addr == REG_COUNTER);
  assign bus_mem_wr = clk_en & reg_wr & reg_addr[MEM_WIN_BIT];
  assign bus_mem_rd = clk_en & reg_rd & reg_addr[MEM_WIN_BIT];
  // bus writes win the single write port; the engine waits in ST_SWAP for as long as bus writes keep coming
  assign eng_wr = (state == ST_SWAP) & clk_en & ~bus_mem_wr;

  // working register slot: r0/r1 pointer for indirect form
  assign slot_idx = is_trade_ind ? {2'b00, instr_opcode[0]}
                                 : instr_opcode[2:0];
  assign reg_slot = wreg_addr(bank_select_flag, slot_idx);

  always_comb begin
    b_re = 1'b0;
    b_addr = reg_slot[DMEM_ADDR_W-1:0];
    if (fire && (is_trade_reg || is_trade_ind)) begin
      b_re = 1'b1;
    end else if (state == ST_PTR) begin
      b_re = 1'b1;
      b_addr = mem_b_q[DMEM_ADDR_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      eng_addr <= '0;
    end else if (clk_en) begin
      unique case (state)
        ST_IDLE: begin
          if (fire && is_trade_reg) begin
            state <= ST_SWAP;
            eng_addr <= b_addr;
          end else if (fire && is_trade_ind) begin
            state <= ST_PTR;
          end
        end
        ST_PTR: begin
          state <= ST_SWAP;
          eng_addr <= b_addr;
        end
        ST_SWAP: begin
          if (!bus_mem_wr) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  assign mem_wr_en = bus_mem_wr | eng_wr;
  assign mem_wr_addr = bus_mem_wr ? reg_addr[DMEM_ADDR_W-1:0] : eng_addr;
  assign mem_wr_data = bus_mem_wr ? reg_wdata : acc;

  arxop_dmem #(
    .ADDR_W(DMEM_ADDR_W),
    .WIDTH(DATA_W)
  ) u_dmem (
    .clk(core_clk),
    .ce(clk_en),
    .wr_en(mem_wr_en),
    .wr_addr(mem_wr_addr),
    .wr_data(mem_wr_data),
    .a_re(bus_mem_rd),
    .a_addr(reg_addr[DMEM_ADDR_W-1:0]),
    .a_q(mem_a_q),
    .b_re(b_re),
    .b_addr(b_addr),
    .b_q(mem_b_q)
  );

  // accumulator
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= RST_ACC;
    end else if (clk_en) begin
      if (wr_acc) begin
        acc <= reg_wdata;
      end else if (eng_wr) begin
        acc <= mem_b_q;
      end else if (fire) begin
        case (instr_opcode)
          OP_ROT_LEFT_C: acc <= {acc[6:0], carry_flag};
          OP_ROT_RIGHT: acc <= {acc[0], acc[7:1]};
          OP_ROT_RIGHT_C: acc <= {carry_flag, acc[7:1]};
          OP_NIBBLE_SWAP: acc <= {acc[3:0], acc[7:4]};
          default: acc <= acc;
        endcase
      end
    end
  end

  // status word: low nibble belongs to other units, reads as zero here
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      program_status_word <= RST_STATUS;
    end else if (clk_en) begin
      if (wr_stat) begin
        program_status_word <= {reg_wdata[7:4], 4'h0};
      end else if (fire) begin
        case (instr_opcode)
          OP_ROT_LEFT_C: program_status_word[STAT_CARRY_BIT] <= acc[7];
          OP_ROT_RIGHT_C: program_status_word[STAT_CARRY_BIT] <= acc[0];
          OP_BANK_ONE: program_status_word[STAT_BANK_BIT] <= 1'b1;
          OP_BANK_ZERO: program_status_word[STAT_BANK_BIT] <= 1'b0;
          default: program_status_word <= program_status_word;
        endcase
      end
    end
  end

  // timer/counter source selection
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tmode <= TM_STOPPED;
    end else if (clk_en && fire) begin
      case (instr_opcode)
        OP_HALT_TC: tmode <= TM_STOPPED;
        OP_BEGIN_EVT: tmode <= TM_EVENT;
        OP_BEGIN_TMR: tmode <= TM_TIMER;
        default: tmode <= tmode;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prescaler <= PRESC_ZERO;
    end else if (clk_en) begin
      if (fire && instr_opcode == OP_BEGIN_TMR) begin
        prescaler <= PRESC_ZERO;
      end else if (tmode == TM_TIMER) begin
        prescaler <= prescaler + PRESC_ONE;
      end
    end
  end

  // pin is synchronous; reset low so no false edge right after reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      event_prev <= 1'b0;
    end else if (clk_en) begin
      event_prev <= event_count_input;
    end
  end

  assign ev_fall = event_prev & ~event_count_input;
  // a start/stop in the same cycle takes precedence over a count
  assign tick = ~tc_cmd & (((tmode == TM_TIMER) &&
                            (prescaler == PRESC_LAST)) ||
                           ((tmode == TM_EVENT) && ev_fall));

  // counter wraps; overflow handling lives elsewhere
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      counter <= RST_COUNTER;
    end else if (clk_en) begin
      if (wr_cnt) begin
        counter <= reg_wdata;
      end else if (tick) begin
        counter <= counter + 8'h01;
      end
    end
  end

  // register read path
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_mem_q <= 1'b0;
      rd_q <= 8'h00;
    end else if (clk_en) begin
      rd_mem_q <= bus_mem_rd;
      if (reg_rd) begin
        case (reg_addr)
          REG_ACC: rd_q <= acc;
          REG_STATUS_WORD: rd_q <= program_status_word;
          REG_COUNTER: rd_q <= counter;
          REG_TC_MODE: rd_q <= {6'h00, tmode};
          default: rd_q <= 8'h00;
        endcase
      end else begin
        rd_q <= 8'h00;
      end
    end
  end

  assign reg_rdata = rd_mem_q ? mem_a_q : rd_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  rot_left_c_a: assert property (
    fire && instr_opcode == OP_ROT_LEFT_C && !wr_acc && !wr_stat |=>
    acc[7:1] == $past(acc[6:0]) && acc[0] == $past(carry_flag) &&
    carry_flag == $past(acc[7]))
    else $error("rotate left via carry wrong");

  plain_rot_right_a: assert property (
    fire && instr_opcode == OP_ROT_RIGHT && !wr_acc && !wr_stat |=>
    acc == {$past(acc[0]), $past(acc[7:1])} && $stable(carry_flag))
    else $error("plain rotate right wrong");

  rot_right_c_a: assert property (
    fire && instr_opcode == OP_ROT_RIGHT_C && !wr_acc && !wr_stat |=>
    acc == {$past(carry_flag), $past(acc[7:1])} &&
    carry_flag == $past(acc[0]))
    else $error("rotate right via carry wrong");

  bank_one_a: assert property (
    fire && instr_opcode == OP_BANK_ONE && !wr_stat |=> bank_select_flag)
    else $error("bank one not selected");

  bank_zero_a: assert property (
    fire && instr_opcode == OP_BANK_ZERO && !wr_stat |=> !bank_select_flag)
    else $error("bank zero not selected");

  // a bus write right after the halt may still load the counter
  halt_stops_a: assert property (
    fire && instr_opcode == OP_HALT_TC && !wr_cnt |=>
    tmode == TM_STOPPED && $stable(counter) ##1
    ($past(wr_cnt) || $stable(counter)))
    else $error("counter moved after halt");

  event_inc_a: assert property (
    tmode == TM_EVENT && clk_en && event_prev && !event_count_input &&
    !tc_cmd && !wr_cnt |=> counter == $past(counter) + 8'h01)
    else $error("event edge not counted");

  timer_inc_a: assert property (
    tmode == TM_TIMER && clk_en && prescaler == PRESC_LAST &&
    !tc_cmd && !wr_cnt |=> counter == $past(counter) + 8'h01)
    else $error("timer tick not counted");

  timer_start_a: assert property (
    fire && instr_opcode == OP_BEGIN_TMR && !wr_cnt |=>
    prescaler == PRESC_ZERO && $stable(counter) && tmode == TM_TIMER)
    else $error("timer start wrong");

  nibble_swap_a: assert property (
    fire && instr_opcode == OP_NIBBLE_SWAP && !wr_acc |=>
    acc == {$past(acc[3:0]), $past(acc[7:4])})
    else $error("nibble swap wrong");

  trade_slot_a: assert property (
    fire && is_trade_reg |=> state == ST_SWAP &&
    8'(eng_addr) == wreg_addr($past(bank_select_flag),
                              $past(instr_opcode[2:0])))
    else $error("register trade address wrong");

  ptr_read_a: assert property (
    fire && is_trade_ind |-> b_re && 8'(b_addr) ==
    (bank_select_flag ? BANK1_BASE : BANK0_BASE) +
    {7'h00, instr_opcode[0]})
    else $error("pointer register address wrong");

  trade_ptr_a: assert property (
    state == ST_PTR && clk_en |=> state == ST_SWAP &&
    eng_addr == $past(mem_b_q[DMEM_ADDR_W-1:0]))
    else $error("indirect pointer not used");

  trade_swap_a: assert property (
    state == ST_SWAP && clk_en && !bus_mem_wr && !wr_acc |=>
    acc == $past(mem_b_q) && state == ST_IDLE)
    else $error("accumulator trade wrong");

  rot_left_c: cover property (fire && instr_opcode == OP_ROT_LEFT_C);
  ind_trade_c: cover property (state == ST_PTR ##1 state == ST_SWAP
                               ##1 state == ST_IDLE);
  timer_tick_c: cover property (tmode == TM_TIMER && tick);
  event_tick_c: cover property (tmode == TM_EVENT && tick);
endmodule // arxop_core

// >>> arxop_dmem.sv
// package of shared constants and the working data memory
package arxop_pkg;
  localparam int DATA_W = 8;
  localparam int PRESC_W = 5;
  localparam int MEM_WIN_BIT = 7;
  // register port offsets
  localparam logic [7:0] REG_ACC = 8'h00;
  localparam logic [7:0] REG_STATUS_WORD = 8'h01;
  localparam logic [7:0] REG_COUNTER = 8'h02;
  localparam logic [7:0] REG_TC_MODE = 8'h03;
  // status word fields
  localparam int STAT_CARRY_BIT = 7;
  localparam int STAT_BANK_BIT = 4;
  // reset values
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_COUNTER = 8'h00;
  // working register bases
  localparam logic [7:0] BANK0_BASE = 8'h00;
  localparam logic [7:0] BANK1_BASE = 8'h18;
  // timing
  localparam logic [PRESC_W-1:0] PRESC_ZERO = 5'h00;
  localparam logic [PRESC_W-1:0] PRESC_ONE = 5'h01;
  localparam logic [PRESC_W-1:0] PRESC_LAST = 5'h1f;
  // opcodes
  localparam logic [7:0] OP_ROT_LEFT_C = 8'hf7;
  localparam logic [7:0] OP_ROT_RIGHT = 8'h77;
  localparam logic [7:0] OP_ROT_RIGHT_C = 8'h67;
  localparam logic [7:0] OP_BANK_ONE = 8'hd5;
  localparam logic [7:0] OP_BANK_ZERO = 8'hc5;
  localparam logic [7:0] OP_HALT_TC = 8'h65;
  localparam logic [7:0] OP_BEGIN_EVT = 8'h45;
  localparam logic [7:0] OP_BEGIN_TMR = 8'h55;
  localparam logic [7:0] OP_NIBBLE_SWAP = 8'h47;
  localparam logic [4:0] OP_TRADE_REG = 5'h05;
  localparam logic [6:0] OP_TRADE_IND = 7'h10;
  typedef enum logic [1:0] {
    TM_STOPPED = 2'b00,
    TM_TIMER = 2'b01,
    TM_EVENT = 2'b10
  } arxop_tmode_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PTR = 2'b01,
    ST_SWAP = 2'b10
  } arxop_state_e;
endpackage

`timescale 1ns/1ps
module arxop_dmem #(
  parameter int ADDR_W = 6,
  parameter int WIDTH = 8
) (
  // clock and enable
  input wire logic clk,
  input wire logic ce,
  // write port
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // read port a
  input wire logic a_re,
  input wire logic [ADDR_W-1:0] a_addr,
  output logic [WIDTH-1:0] a_q,
  // read port b
  input wire logic b_re,
  input wire logic [ADDR_W-1:0] b_addr,
  output logic [WIDTH-1:0] b_q
);
  logic [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge clk) begin
    if (ce && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read data registered; old data on a same-address write
  always_ff @(posedge clk) begin
    if (ce && a_re) begin
      a_q <= mem[a_addr];
    end
  end

  always_ff @(posedge clk) begin
    if (ce && b_re) begin
      b_q <= mem[b_addr];
    end
  end
endmodule // arxop_dmem

// >>> arxop_tb_top.sv
// self-checking testbench for the accumulator rotate and timer unit
`timescale 1ns/1ps
module arxop_tb_top import arxop_pkg::*;;
  logic core_clk;
  logic arst_n;
  logic clk_en;
  logic instr_valid;
  logic [7:0] instr_opcode;
  logic instr_ready;
  logic event_count_input;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  int fails;
  int total_checks;

  arxop_core arxop_core_i (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .instr_valid(instr_valid),
    .instr_opcode(instr_opcode),
    .instr_ready(instr_ready),
    .event_count_input(event_count_input),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata)
  );

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic rdchk(input string what, input logic [7:0] a,
                       input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(what, d, exp);
  endtask

  // offer opcode, hold until taken, then wait for the engine to go idle
  task automatic issue(input logic [7:0] op);
    int n;
    logic took;
    n = 0;
    took = 1'b0;
    @(posedge core_clk);
    instr_valid <= 1'b1;
    instr_opcode <= op;
    // ready looked at once settled, ahead of the edge that takes
    do begin
      #1 took = (instr_ready === 1'b1);
      @(posedge core_clk);
      n++;
    end while (!took && n < 50);
    instr_valid <= 1'b0;
    if (!took) check("taken", {7'h00, took}, 8'h01);
    n = 0;
    do begin
      @(posedge core_clk);
      #1 n++;
    end while (instr_ready !== 1'b1 && n < 50);
    if (n >= 50) check("ready", {7'h00, instr_ready}, 8'h01);
  endtask

  task automatic t_reset;
    rdchk("acc", REG_ACC, RST_ACC);
    rdchk("status", REG_STATUS_WORD, RST_STATUS);
    rdchk("counter", REG_COUNTER, RST_COUNTER);
    rdchk("mode", REG_TC_MODE, 8'h00);
    wr(8'h40, 8'h77);
    rdchk("unmapped", 8'h40, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_rotate;
    wr(REG_ACC, 8'h81);
    wr(REG_STATUS_WORD, 8'h00);
    issue(OP_ROT_LEFT_C);
    rdchk("rlc acc", REG_ACC, 8'h02);
    rdchk("rlc carry", REG_STATUS_WORD, 8'h80);
    issue(OP_ROT_RIGHT_C);
    rdchk("rrc acc", REG_ACC, 8'h81);
    rdchk("rrc carry", REG_STATUS_WORD, 8'h00);
    wr(REG_STATUS_WORD, 8'h80);
    issue(OP_ROT_RIGHT);
    rdchk("rr acc", REG_ACC, 8'hc0);
    rdchk("rr carry", REG_STATUS_WORD, 8'h80);
    issue(OP_NIBBLE_SWAP);
    rdchk("swap acc", REG_ACC, 8'h0c);
    $display("test rotate done");
  endtask

  task automatic t_trade;
    wr(REG_STATUS_WORD, 8'h00);
    issue(OP_BANK_ONE);
    rdchk("bank one", REG_STATUS_WORD, 8'h10);
    wr(8'h9b, 8'h33);
    wr(8'h83, 8'h66);
    wr(REG_ACC, 8'ha5);
    issue({OP_TRADE_REG, 3'd3});
    rdchk("trade b1 acc", REG_ACC, 8'h33);
    rdchk("trade b1 mem", 8'h9b, 8'ha5);
    rdchk("bank0 r3 kept", 8'h83, 8'h66);
    // pointer above six bits must be cut to the 64-byte window
    wr(8'h99, 8'h7a);
    wr(8'hba, 8'h44);
    wr(REG_ACC, 8'h99);
    issue({OP_TRADE_IND, 1'b1});
    rdchk("ind acc", REG_ACC, 8'h44);
    rdchk("ind mem", 8'hba, 8'h99);
    issue(OP_BANK_ZERO);
    rdchk("bank zero", REG_STATUS_WORD, 8'h00);
    issue({OP_TRADE_REG, 3'd3});
    rdchk("trade b0 acc", REG_ACC, 8'h66);
    rdchk("trade b0 mem", 8'h83, 8'h44);
    wr(8'h80, 8'h05);
    wr(8'h85, 8'h21);
    issue({OP_TRADE_IND, 1'b0});
    rdchk("ind r0 acc", REG_ACC, 8'h21);
    rdchk("ind r0 mem", 8'h85, 8'h66);
    $display("test trade done");
  endtask

  task automatic t_timer;
    wr(REG_COUNTER, 8'h10);
    issue(OP_BEGIN_TMR);
    rdchk("timer mode", REG_TC_MODE, 8'h01);
    idle(15);
    rdchk("cnt kept", REG_COUNTER, 8'h10);
    // restart before 32 cycles: a stale prescaler would tick too soon
    issue(OP_BEGIN_TMR);
    idle(20);
    rdchk("presc clr", REG_COUNTER, 8'h10);
    idle(15);
    rdchk("tick one", REG_COUNTER, 8'h11);
    idle(30);
    rdchk("tick two", REG_COUNTER, 8'h12);
    issue(OP_HALT_TC);
    rdchk("halt mode", REG_TC_MODE, 8'h00);
    idle(40);
    rdchk("halt timer", REG_COUNTER, 8'h12);
    $display("test timer done");
  endtask

  task automatic pulse_pin;
    @(posedge core_clk);
    event_count_input <= 1'b0;
    idle(3);
    event_count_input <= 1'b1;
    idle(3);
  endtask

  task automatic t_event;
    wr(REG_COUNTER, 8'hfe);
    issue(OP_BEGIN_EVT);
    rdchk("event mode", REG_TC_MODE, 8'h02);
    repeat (3) pulse_pin;
    rdchk("events wrap", REG_COUNTER, 8'h01);
    issue(OP_HALT_TC);
    repeat (2) pulse_pin;
    rdchk("halt event", REG_COUNTER, 8'h01);
    $display("test event done");
  endtask

  // with the enable low nothing is taken, on either port
  task automatic t_enable;
    wr(REG_ACC, 8'h5a);
    @(posedge core_clk);
    clk_en <= 1'b0;
    instr_valid <= 1'b1;
    instr_opcode <= OP_ROT_LEFT_C;
    reg_wr <= 1'b1;
    reg_wdata <= 8'hff;
    idle(3);
    instr_valid <= 1'b0;
    reg_wr <= 1'b0;
    clk_en <= 1'b1;
    rdchk("frozen acc", REG_ACC, 8'h5a);
    $display("test enable done");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    fails++;
    $display("BAD watchdog expected end seen hang");
    test_done;
  end

  initial begin
    fails = 0;
    total_checks = 0;
    arst_n = 1'b0;
    clk_en = 1'b1;
    instr_valid = 1'b0;
    instr_opcode = 8'h00;
    event_count_input = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    idle(2);
    arst_n <= 1'b1;
    idle(3);
    t_reset;
    t_rotate;
    t_trade;
    t_timer;
    t_event;
    t_enable;
    test_done;
  end
endmodule // arxop_tb_top
